// >>> verilog/sfc_core.sv
`timescale 1ns/100ps
// ========================================
// Behaviour
// - write-enable code sets write_enable_latch
// - non-volatile status writes need write_enable_latch set beforehand
// - volatile enable leaves latch alone, arms only the next command, which must be the status write
// - write-disable code clears write_enable_latch
// - latch clears at power-up and when a write cycle completes
// - status read codes shift the chosen register out, MSB first
// - status reads work while busy and repeat until select rises
// - status writes change only the writable bits
// - lock bits are one-time: once one, no write clears them
// - non-volatile status write needs enable, code, then one data byte
// - volatile status write updates volatile copies, latch stays zero
// - reset reloads every status bit from its non-volatile copy
// - non-volatile write runs a timed busy cycle, then clears latch
// - volatile write applies at once with busy kept zero
// - register-one code with sixteen data bits writes registers one and two
// - read code plus 24-bit address, then bytes out on falling edges
// - address increments after each byte until select rises
// - array reads while busy are ignored
// - fast read inserts eight dummy clocks before data
// - dual fast read drives two bits per clock on both lines
// - even bits on line zero, odd on line one, high pair first
// - every byte moves most significant bit first
module sfc_core #(
    parameter int WRITE_NS = sfc_pkg::T_WRITE_NS, // self-timed write length
    parameter int FIFO_DEPTH = sfc_pkg::FIFO_DEPTH // read prefetch depth
) (
    input wire logic CLK, // core clock
    input wire logic ARST_N, // async reset, power-up
    input wire sfc_pkg::sfc_pins_t PINS, // raw serial pins
    output logic IO0_OUT, // line zero drive value
    output logic IO0_OE, // line zero driven
    output logic IO1_OUT, // line one drive value
    output logic IO1_OE, // line one driven
    output logic [23:0] MEM_ADDR, // array fetch address
    output logic MEM_REQ, // fetch valid
    input wire logic [7:0] MEM_RDATA, // array byte for MEM_ADDR
    output sfc_pkg::sfc_status_t STATUS // live status registers
);
    import sfc_pkg::*;

    // ========================================
    // derived constants
    localparam int WR_RAW = (WRITE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
    localparam int BW = 20;
    localparam logic [5:0] OPC_END = 6'd7;
    localparam logic [5:0] ADDR_END = 6'(7 + ADDR_BITS);
    localparam logic [5:0] DUMMY_END = 6'(7 + ADDR_BITS + DUMMY_CLKS);
    if (WR_CYC >= (1 << BW)) begin : g_chk
        $error("write time too long for busy counter");
    end

    function automatic logic [7:0] f_wr(input logic [7:0] old, input logic [7:0] data,
                                        input logic [7:0] mask, input logic [7:0] otp);
        return (old & ~mask) | (data & mask) | (old & otp);
    endfunction

    function automatic sfc_state_t f_disp(input logic [7:0] op, input logic bsy);
        case (op)
            OP_RDSR1, OP_RDSR2, OP_RDSR3: f_disp = ST_STAT;
            OP_READ, OP_FREAD, OP_DREAD: f_disp = bsy ? ST_HOLD : ST_ADDR;
            OP_WRSR1, OP_WRSR2, OP_WRSR3: f_disp = ST_WDATA;
            default: f_disp = ST_HOLD;
        endcase
    endfunction

    sfc_pins_t s1_ff;
    sfc_pins_t s2_ff;
    logic sck_q_ff;
    logic csn_q_ff;
    sfc_state_t st_ff;
    sfc_state_t nxt_st;
    logic [5:0] cnt_ff;
    logic [7:0] shin_ff;
    logic [7:0] op_ff;
    logic [23:0] addr_ff;
    logic [7:0] wd1_ff;
    logic [7:0] wd2_ff;
    logic [7:0] shout_ff;
    logic [2:0] left_ff;
    logic out_on_ff;
    logic dual_ff;
    logic io0_ff;
    logic io0_oe_ff;
    logic io1_ff;
    logic io1_oe_ff;
    logic [23:0] maddr_ff;
    logic mreq_ff;
    logic [7:0] sr1_ff;
    logic [7:0] sr2_ff;
    logic [7:0] sr3_ff;
    logic [7:0] nv1_ff;
    logic [7:0] nv2_ff;
    logic [7:0] nv3_ff;
    logic [BW-1:0] bcnt_ff;
    logic varm_ff;
    logic rarm_ff;
    logic [7:0] nxt_sr1;
    logic [7:0] nxt_sr2;
    logic [7:0] nxt_sr3;
    logic [7:0] nxt_nv1;
    logic [7:0] nxt_nv2;
    logic [7:0] nxt_nv3;
    logic [BW-1:0] nxt_bcnt;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;

    // ========================================
    // pin synchroniser; only the second stage is looked at
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1_ff <= PIN_IDLE;
            s2_ff <= PIN_IDLE;
            sck_q_ff <= 1'b0;
            csn_q_ff <= 1'b1;
        end else begin
            s1_ff <= PINS;
            s2_ff <= s1_ff;
            sck_q_ff <= s2_ff.sck;
            csn_q_ff <= s2_ff.cs_n;
        end
    end

    // edge and frame decode
    wire sel = ~s2_ff.cs_n;
    wire cs_fall = sel & csn_q_ff;
    wire cs_rise = s2_ff.cs_n & ~csn_q_ff;
    wire rise = sel & s2_ff.sck & ~sck_q_ff;
    wire step = sel & ~s2_ff.sck & sck_q_ff & out_on_ff;
    wire din = s2_ff.io0;
    wire [7:0] nxt_shin = {shin_ff[6:0], din};
    wire [23:0] nxt_addr = {addr_ff[22:0], din};
    wire busy = sr1_ff[SR1_BUSY_BIT];
    wire write_enable_latch = sr1_ff[SR1_WEL_BIT];

    // ========================================
    // command completion at select rising
    wire one_byte = (cnt_ff == 6'd8);
    wire done = cs_rise & (cnt_ff >= 6'd8);
    wire do_wren = cs_rise & one_byte & (op_ff == OP_WREN) & ~busy;
    wire do_wrdi = cs_rise & one_byte & (op_ff == OP_WRDI) & ~busy;
    wire do_varm = one_byte & (op_ff == OP_VWREN);
    wire do_rarm = one_byte & (op_ff == OP_RSTEN);
    wire sw_rst = cs_rise & one_byte & (op_ff == OP_RST) & rarm_ff & ~busy;
    wire reload = ~s2_ff.rst_n | sw_rst;
    wire is_wrsr = (op_ff == OP_WRSR1) | (op_ff == OP_WRSR2) | (op_ff == OP_WRSR3);
    // unenabled writes fall out here and leave no trace
    wire wr_ok = cs_rise & is_wrsr & ~busy & (cnt_ff >= 6'd16) & (write_enable_latch | varm_ff);
    wire nv_wr = wr_ok & ~varm_ff;
    wire sel_r1 = wr_ok & (op_ff == OP_WRSR1);
    wire two_byte = (op_ff == OP_WRSR1) & (cnt_ff >= 6'd24);
    wire sel_r2 = wr_ok & ((op_ff == OP_WRSR2) | two_byte);
    wire sel_r3 = wr_ok & (op_ff == OP_WRSR3);
    wire [7:0] r2_data = (op_ff == OP_WRSR1) ? wd2_ff : wd1_ff;
    wire [7:0] new1 = f_wr(sr1_ff, wd1_ff, SR1_WR_MASK, 8'h00);
    wire [7:0] new2 = f_wr(sr2_ff, r2_data, SR2_WR_MASK, SR2_OTP_MASK);
    wire [7:0] new3 = f_wr(sr3_ff, wd1_ff, SR3_WR_MASK, 8'h00);

    // ========================================
    // instruction sequencer
    wire last_addr = (st_ff == ST_ADDR) & (cnt_ff == ADDR_END);
    wire last_dummy = (st_ff == ST_DUMMY) & (cnt_ff == DUMMY_END);
    assign nxt_st = (cnt_ff == OPC_END) ? f_disp(nxt_shin, busy) :
                    last_addr ? ((op_ff == OP_READ) ? ST_READ : ST_DUMMY) :
                    last_dummy ? ST_READ : st_ff;
    wire addr_done = rise & last_addr;
    wire out_start = rise & (nxt_st != st_ff) & ((nxt_st == ST_STAT) | (nxt_st == ST_READ));
    wire [5:0] nxt_cnt = (cnt_ff == 6'h3F) ? cnt_ff : cnt_ff + 6'd1;

    // falling select restarts decode, rising parks it
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_ff <= ST_IDLE;
            cnt_ff <= '0;
            shin_ff <= '0;
            op_ff <= '0;
            addr_ff <= '0;
            wd1_ff <= '0;
            wd2_ff <= '0;
        end else if (cs_fall) begin
            st_ff <= ST_OPCODE;
            cnt_ff <= '0;
        end else if (cs_rise) begin
            st_ff <= ST_IDLE;
        end else if (rise) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            shin_ff <= nxt_shin;
            if (cnt_ff == OPC_END) op_ff <= nxt_shin;
            if (st_ff == ST_ADDR) addr_ff <= nxt_addr;
            if (st_ff == ST_WDATA && cnt_ff == 6'd15) wd1_ff <= nxt_shin;
            if (st_ff == ST_WDATA && cnt_ff == 6'd23) wd2_ff <= nxt_shin;
        end
    end

    // ========================================
    // output shifter: a new byte is taken whenever the last one ran out
    wire load = step & (left_ff == 3'd0);
    wire [7:0] stat_sel = (op_ff == OP_RDSR2) ? sr2_ff :
                          (op_ff == OP_RDSR3) ? sr3_ff : sr1_ff;
    // an empty prefetch buffer sends zero; only a very fast link can hit it
    wire [7:0] src = (st_ff == ST_READ) ? (fifo_valid ? fifo_data : 8'h00) : stat_sel;
    wire [7:0] cur = load ? src : shout_ff;
    wire [7:0] nxt_shout = dual_ff ? {cur[5:0], 2'b00} : {cur[6:0], 1'b0};
    wire [2:0] nxt_left = load ? (dual_ff ? 3'd3 : 3'd7) : left_ff - 3'd1;
    wire pop = load & (st_ff == ST_READ);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            out_on_ff <= 1'b0;
            dual_ff <= 1'b0;
            shout_ff <= '0;
            left_ff <= '0;
            io0_ff <= 1'b0;
            io1_ff <= 1'b0;
            io0_oe_ff <= 1'b0;
            io1_oe_ff <= 1'b0;
        end else if (cs_rise | cs_fall) begin
            out_on_ff <= 1'b0;
            dual_ff <= 1'b0;
            left_ff <= '0;
            io0_oe_ff <= 1'b0;
            io1_oe_ff <= 1'b0;
        end else if (out_start) begin
            out_on_ff <= 1'b1;
            dual_ff <= (op_ff == OP_DREAD);
        end else if (step) begin
            io1_ff <= cur[7];
            io0_ff <= cur[6];
            shout_ff <= nxt_shout;
            left_ff <= nxt_left;
            io1_oe_ff <= 1'b1;
            io0_oe_ff <= dual_ff; // line zero taken at first data fall, in dual reads only
        end
    end

    // ========================================
    // array prefetch; a full buffer stalls the fetch
    wire push = mreq_ff & fifo_in_ready;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mreq_ff <= 1'b0;
            maddr_ff <= '0;
        end else if (cs_rise | cs_fall) begin
            mreq_ff <= 1'b0;
        end else if (addr_done) begin
            mreq_ff <= 1'b1;
            maddr_ff <= nxt_addr;
        end else if (push) begin
            maddr_ff <= maddr_ff + 24'h000001;
        end
    end

    sfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .arst_n(ARST_N),
        .clr(cs_rise | cs_fall),
        .in_valid(mreq_ff),
        .in_data(MEM_RDATA),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(pop)
    );

    // ========================================
    // status next state; reload beats any command
    always_comb begin
        nxt_sr1 = sr1_ff;
        nxt_sr2 = sr2_ff;
        nxt_sr3 = sr3_ff;
        nxt_nv1 = nv1_ff;
        nxt_nv2 = nv2_ff;
        nxt_nv3 = nv3_ff;
        nxt_bcnt = bcnt_ff;
        if (busy) begin
            nxt_bcnt = bcnt_ff - BW'(1);
        end
        if (busy && bcnt_ff == BW'(1)) begin
            nxt_sr1[SR1_BUSY_BIT] = 1'b0;
            nxt_sr1[SR1_WEL_BIT] = 1'b0;
        end
        if (reload) begin
            nxt_sr1 = nv1_ff;
            nxt_sr2 = nv2_ff;
            nxt_sr3 = nv3_ff;
            nxt_bcnt = '0;
        end else begin
            if (do_wren) nxt_sr1[SR1_WEL_BIT] = 1'b1;
            if (do_wrdi) nxt_sr1[SR1_WEL_BIT] = 1'b0;
            // volatile writes land here at once with busy left low
            if (sel_r1) nxt_sr1 = new1;
            if (sel_r2) nxt_sr2 = new2;
            if (sel_r3) nxt_sr3 = new3;
            if (nv_wr) begin
                if (sel_r1) nxt_nv1 = new1 & SR1_WR_MASK;
                if (sel_r2) nxt_nv2 = new2 & SR2_WR_MASK;
                if (sel_r3) nxt_nv3 = new3 & SR3_WR_MASK;
                nxt_sr1[SR1_BUSY_BIT] = 1'b1;
                nxt_bcnt = BW'(WR_CYC);
            end
        end
    end

    // status registers; arms last for exactly the next command
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sr1_ff <= SR_RST;
            sr2_ff <= SR_RST;
            sr3_ff <= SR_RST;
            nv1_ff <= SR_RST;
            nv2_ff <= SR_RST;
            nv3_ff <= SR_RST;
            bcnt_ff <= '0;
            varm_ff <= 1'b0;
            rarm_ff <= 1'b0;
        end else begin
            sr1_ff <= nxt_sr1;
            sr2_ff <= nxt_sr2;
            sr3_ff <= nxt_sr3;
            nv1_ff <= nxt_nv1;
            nv2_ff <= nxt_nv2;
            nv3_ff <= nxt_nv3;
            bcnt_ff <= nxt_bcnt;
            if (reload) varm_ff <= 1'b0;
            else if (done) varm_ff <= do_varm;
            if (reload) rarm_ff <= 1'b0;
            else if (done) rarm_ff <= do_rarm;
        end
    end

    assign IO0_OUT = io0_ff;
    assign IO0_OE = io0_oe_ff;
    assign IO1_OUT = io1_ff;
    assign IO1_OE = io1_oe_ff;
    assign MEM_ADDR = maddr_ff;
    assign MEM_REQ = mreq_ff;
    assign STATUS = '{sr3: sr3_ff, sr2: sr2_ff, sr1: sr1_ff};

    // ========================================
    // checks
    property p_wren;
        @(posedge CLK) disable iff (!ARST_N) do_wren |=> write_enable_latch;
    endproperty
    a_wren: assert property (p_wren) else $error("enable did not set latch");

    property p_wrdi;
        @(posedge CLK) disable iff (!ARST_N) (do_wrdi & ~reload) |=> !write_enable_latch;
    endproperty
    a_wrdi: assert property (p_wrdi) else $error("disable left latch set");

    property p_nowel;
        @(posedge CLK) disable iff (!ARST_N)
            (cs_rise & is_wrsr & ~write_enable_latch & ~varm_ff & ~reload) |=> $stable(sr2_ff) && !busy;
    endproperty
    a_nowel: assert property (p_nowel) else $error("unenabled write acted");

    property p_vol;
        @(posedge CLK) disable iff (!ARST_N) (wr_ok & varm_ff & ~write_enable_latch) |=> !write_enable_latch && !busy;
    endproperty
    a_vol: assert property (p_vol) else $error("volatile write touched latch");

    property p_busy_end;
        @(posedge CLK) disable iff (!ARST_N)
            (busy && bcnt_ff == BW'(1) && !reload) |=> !busy && !write_enable_latch;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("write cycle end wrong");

    property p_otp;
        @(posedge CLK) disable iff (!ARST_N)
            !reload |=> ((sr2_ff & $past(sr2_ff) & SR2_OTP_MASK) ==
                         ($past(sr2_ff) & SR2_OTP_MASK));
    endproperty
    a_otp: assert property (p_otp) else $error("lock bit cleared");

    property p_rd_busy;
        @(posedge CLK) disable iff (!ARST_N)
            (rise & busy & (cnt_ff == OPC_END) & (nxt_shin == OP_READ)) |=> st_ff == ST_HOLD;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");

    property p_cs_end;
        @(posedge CLK) disable iff (!ARST_N) cs_rise |=> !IO0_OE && !IO1_OE && !MEM_REQ;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("output after select rose");

    property p_msb;
        @(posedge CLK) disable iff (!ARST_N) (load & ~dual_ff) |=> IO1_OUT == $past(src[7]);
    endproperty
    a_msb: assert property (p_msb) else $error("first bit not msb");

    property p_dual;
        @(posedge CLK) disable iff (!ARST_N) IO0_OE |-> dual_ff && IO1_OE;
    endproperty
    a_dual: assert property (p_dual) else $error("line zero driven outside dual");
endmodule

// >>> verilog/sfc_pkg.sv
package sfc_pkg;
    // ========================================
    // clock and timing
    localparam int CLK_HZ = 40_000_000; // core clock rate
    localparam int T_WRITE_NS = 10_000; // self-timed status write, plain default
    // ========================================
    // instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_DREAD = 8'h3B;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    // ========================================
    // status fields, masks and reset values
    localparam int SR1_BUSY_BIT = 0; // busy flag position
    localparam int SR1_WEL_BIT = 1; // write_enable_latch position
    localparam logic [7:0] SR1_WR_MASK = 8'hFC; // mode, unit size, top/bottom, range
    localparam logic [7:0] SR2_WR_MASK = 8'h7B; // invert, lock bits, io enable, lock
    localparam logic [7:0] SR3_WR_MASK = 8'hE4; // pause, strength, scheme
    localparam logic [7:0] SR2_OTP_MASK = 8'h39; // one_time_lock_bits and status_lock
    localparam logic [7:0] SR_RST = 8'h00; // status value at power-up
    // ========================================
    // frame geometry
    localparam int ADDR_BITS = 24; // address length
    localparam int DUMMY_CLKS = 8; // dummy clocks of fast reads
    localparam int FIFO_DEPTH = 8; // read prefetch depth
    // ========================================
    // types
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic io0;
        logic rst_n;
    } sfc_pins_t;
    typedef struct packed {
        logic [7:0] sr3;
        logic [7:0] sr2;
        logic [7:0] sr1;
    } sfc_status_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_STAT, ST_WDATA, ST_HOLD
    } sfc_state_t;
    localparam sfc_pins_t PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, io0: 1'b0, rst_n: 1'b1};
endpackage

// >>> verilog/sfc_fifo.sv
`timescale 1ns/100ps
module sfc_fifo #(
    parameter int WIDTH = 8, // word width
    parameter int DEPTH = 8 // words, power of two
) (
    input wire logic clk, // core clock
    input wire logic arst_n, // async reset
    input wire logic clr, // drop all words
    input wire logic in_valid, // word offered
    input wire logic [WIDTH-1:0] in_data, // offered word
    output logic in_ready, // room left
    output logic out_valid, // word waiting
    output logic [WIDTH-1:0] out_data, // oldest word
    input wire logic out_ready // consumer takes word
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;

    // ========================================
    // flags: extra pointer bit tells full from empty
    wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    wire empty = (wp_ff == rp_ff);
    wire push = in_valid & ~full;
    wire pop = out_ready & ~empty;
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem_ff[rp_ff[AW-1:0]];

    // pointers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else if (clr) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= wp_ff + (AW+1)'(push);
            rp_ff <= rp_ff + (AW+1)'(pop);
        end
    end

    // storage needs no reset, flags guard stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= in_data;
        end
    end
endmodule

// >>> verification/sfc_host.sv
`timescale 1ns/100ps
// ========================================
// host side of the link: mode 0, one link clock is 8 core clocks
module sfc_host (
    input wire logic clk, // core clock
    input wire logic io0_w, // line zero level
    input wire logic io1_w, // line one level
    output sfc_pkg::sfc_pins_t pins // pins toward the device
);
    import sfc_pkg::*;
    initial pins = PIN_IDLE;
    // one framed transfer: tx leaves from bit 63, rx gathers what came back
    task automatic frame(input logic [63:0] tx, input int n, input bit dual,
                         output logic [63:0] rx);
        logic [63:0] r1;
        logic [63:0] r2;
        r1 = '0;
        r2 = '0;
        @(posedge clk);
        pins.cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            // dual: line zero let go from the dummies on, so it wiggles
            pins.io0 <= (dual && i >= 32) ? ~pins.io0 : tx[63-i];
            repeat (4) @(posedge clk);
            pins.sck <= 1'b1;
            // sample late in the high phase, clear of the device's update
            repeat (3) @(posedge clk);
            @(negedge clk);
            r1 = {r1[62:0], io1_w};
            r2 = {r2[61:0], io1_w, io0_w};
            @(posedge clk);
            pins.sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        pins.cs_n <= 1'b1;
        pins.io0 <= ~pins.io0; // no longer meaningful
        repeat (8) @(posedge clk);
        rx = dual ? r2 : r1;
    endtask
    // hardware reset pin pulse
    task automatic pin_reset();
        @(posedge clk);
        pins.rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        pins.rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// >>> verification/serial_flash_status_and_read_commands_tb.sv
`timescale 1ns/100ps
module serial_flash_status_and_read_commands_tb;
    import sfc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    sfc_pins_t hp;
    sfc_pins_t pins;
    logic io0_out, io0_oe, io1_out, io1_oe, mem_req;
    logic [23:0] mem_addr;
    logic [7:0] mem_rdata;
    sfc_status_t status;
    logic [63:0] rx;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // ========================================
    // clock, wires, array stand-in
    always #12.5 clk = ~clk;
    function automatic logic [7:0] mbyte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    assign mem_rdata = mbyte(mem_addr); // combinational, as the fetch port needs
    assign pins = '{cs_n: hp.cs_n, sck: hp.sck, io0: io0_oe ? io0_out : hp.io0,
                    rst_n: hp.rst_n};
    sfc_host host (.clk(clk), .io0_w(pins.io0), .io1_w(io1_oe ? io1_out : hp.sck),
                   .pins(hp));
    // write time raised to 800 core clocks, longer than two probe frames
    sfc_core #(.WRITE_NS(20000)) dut (.CLK(clk), .ARST_N(arst_n), .PINS(pins),
        .IO0_OUT(io0_out), .IO0_OE(io0_oe), .IO1_OUT(io1_out), .IO1_OE(io1_oe),
        .MEM_ADDR(mem_addr), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .STATUS(status));
    // ========================================
    // helpers
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        host.frame({op, 56'h0}, 8, 1'b0, rx);
    endtask
    task automatic wr(input logic [7:0] op, input logic [15:0] d, input int n);
        host.frame({op, d, 40'h0}, n, 1'b0, rx);
    endtask
    task automatic rd_sr(input logic [7:0] op, input logic [7:0] exp);
        host.frame({op, 56'h0}, 24, 1'b0, rx);
        check(rx[15:0], {exp, exp}, "status read");
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 1000 && status.sr1[0] !== 1'b0; i++) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the expected run of about 4300 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            finish_test();
        end
    end
    // ========================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(status, 24'h0, "reset value");
        host.frame({OP_WREN, 56'h0}, 5, 1'b0, rx);
        check(status.sr1, 8'h00, "cut frame");
        cmd(OP_WREN);
        check(status.sr1, 8'h02, "latch set");
        cmd(OP_WRDI);
        check(status.sr1, 8'h00, "latch clear");
        wr(OP_WRSR1, 16'hFF00, 16);
        check(status, 24'h0, "unenabled write");
        // non-volatile pair write, probed while the cycle runs
        cmd(OP_WREN);
        wr(OP_WRSR1, 16'hA4FF, 24);
        check(status.sr1[1:0], 2'b11, "busy with latch");
        host.frame({OP_RDSR1, 56'h0}, 24, 1'b0, rx);
        check({rx[9:8], rx[1:0]}, 4'hF, "status while busy");
        // eight clocks past the address: an undriven line one shows the high clock level
        host.frame({OP_READ, 56'h0}, 40, 1'b0, rx);
        check({mem_req, status.sr1[0], rx[7:0]}, {2'b01, 8'hFF}, "read while busy");
        wait_idle();
        check(status, {8'h00, 8'h7B, 8'hA4}, "pair written");
        rd_sr(OP_RDSR2, 8'h7B);
        // volatile writes: latch and busy stay low
        cmd(OP_VWREN);
        check(status.sr1[1], 1'b0, "arm leaves latch");
        wr(OP_WRSR1, 16'h5C00, 16);
        check(status, {8'h00, 8'h7B, 8'h5C}, "volatile byte");
        cmd(OP_VWREN);
        wr(OP_WRSR2, 16'h0000, 16);
        check(status.sr2, 8'h39, "lock bits kept");
        cmd(OP_VWREN);
        wr(OP_WRSR3, 16'hFF00, 16);
        rd_sr(OP_RDSR3, 8'hE4);
        cmd(OP_VWREN);
        cmd(OP_WRDI);
        wr(OP_WRSR1, 16'h0000, 16);
        rd_sr(OP_RDSR1, 8'h5C);
        host.pin_reset();
        check(status, {8'h00, 8'h7B, 8'hA4}, "reload");
        // array reads across byte and page boundaries
        host.frame({OP_READ, 24'h0000FE, 32'h0}, 56, 1'b0, rx);
        check(rx[23:0], {mbyte(24'hFE), mbyte(24'hFF), mbyte(24'h100)}, "read");
        host.frame({OP_FREAD, 24'h123456, 32'h0}, 56, 1'b0, rx);
        check(rx[15:0], {mbyte(24'h123456), mbyte(24'h123457)}, "fast read");
        host.frame({OP_DREAD, 24'h00FFFF, 32'h0}, 48, 1'b1, rx);
        check(rx[15:0], {mbyte(24'h00FFFF), mbyte(24'h010000)}, "dual");
        finish_test();
    end
endmodule
